// ===== hdl/sdoes_regs.svh
// constants of the expedited sdo server
`ifndef SDOES_REGS_SVH
`define SDOES_REGS_SVH
// frame identifiers and length
`define SDOES_RX_ID_BASE    11'h600
`define SDOES_TX_ID_BASE    11'h580
`define SDOES_FRAME_DLC     4'h8
// command byte layout
`define SDOES_CCS_DOWNLOAD  3'h1
`define SDOES_CMD_RSVD_BIT  4
`define SDOES_CMD_N_LSB     2
`define SDOES_CMD_E_BIT     1
`define SDOES_CMD_S_BIT     0
`define SDOES_CMD_UPLOAD    8'h40
`define SDOES_CMD_RD_1      8'h4F
`define SDOES_CMD_RD_2      8'h4B
`define SDOES_CMD_RD_4      8'h43
`define SDOES_CMD_WR_ACK    8'h60
`define SDOES_CMD_ABORT     8'h80
// abort codes
`define SDOES_AB_CMD        32'h0504_0001
`define SDOES_AB_WO         32'h0601_0001
`define SDOES_AB_RO         32'h0601_0002
`define SDOES_AB_NO_INDEX   32'h0602_0000
`define SDOES_AB_NO_MAP     32'h0604_0041
`define SDOES_AB_FAULT      32'h0606_0000
`define SDOES_AB_LEN        32'h0607_0010
`define SDOES_AB_LEN_HI     32'h0607_0012
`define SDOES_AB_LEN_LO     32'h0607_0013
`define SDOES_AB_SUB        32'h0609_0011
`define SDOES_AB_RANGE      32'h0609_0030
`define SDOES_AB_VAL_HI     32'h0609_0031
`define SDOES_AB_VAL_LO     32'h0609_0032
`define SDOES_AB_STATE      32'h0800_0022
// object dictionary
`define SDOES_IDX_STORE     16'h1010
`define SDOES_IDX_MAP       16'h1A00
`define SDOES_IDX_CTRL      16'h6040
`define SDOES_IDX_STAT      16'h6041
`define SDOES_IDX_MODE      16'h6060
`define SDOES_IDX_POS_ACT   16'h6064
`define SDOES_IDX_TGT_POS   16'h607A
`define SDOES_IDX_HOME_METH 16'h6098
`define SDOES_IDX_HOME_SPD  16'h6099
`define SDOES_SUB_0         8'h00
`define SDOES_SUB_1         8'h01
`define SDOES_SUB_2         8'h02
`define SDOES_SZ_1          3'h1
`define SDOES_SZ_2          3'h2
`define SDOES_SZ_3          3'h3
`define SDOES_SZ_4          3'h4
// value ranges and control
`define SDOES_MODE_MIN      8'h01
`define SDOES_MODE_MAX      8'h0A
`define SDOES_MODE_PP       8'h01
`define SDOES_MODE_PV       8'h03
`define SDOES_MODE_PT       8'h04
`define SDOES_MODE_HOMING   8'h06
`define SDOES_METH_MIN      8'h01
`define SDOES_METH_MAX      8'h23
`define SDOES_CTRL_ENABLE   4'hF
`define SDOES_CTRL_START    4
`define SDOES_SW_ORIGIN     15
`define SDOES_SW_HOMING     12
`define SDOES_SW_FAULT      3
// bus registers and reset values
`define SDOES_REG_CTRL      8'h00
`define SDOES_REG_STATUS    8'h04
`define SDOES_REG_ABORT     8'h08
`define SDOES_RST_WORD      32'h0000_0000
`define SDOES_RST_CTRL      16'h0000
`define SDOES_RST_MODE      8'h00
`endif

// ===== hdl/sdoes_pkg.sv
// types of the expedited sdo server
package sdoes_pkg;
  typedef enum logic [1:0] {
    SDOES_IDLE  = 2'b01,
    SDOES_REPLY = 2'b10
  } sdoes_state_t;
  typedef logic [2:0] sdoes_size_t;
endpackage

// ===== hdl/sdoes_od_map.sv
// object dictionary attributes: presence, subindex, size and access
`timescale 1ns/1ps
`default_nettype none
`include "sdoes_regs.svh"
module sdoes_od_map (
  // object address
  input  wire logic [15:0]           index,
  input  wire logic [7:0]            subindex,
  // attributes
  output logic                       known,
  output logic                       sub_ok,
  output sdoes_pkg::sdoes_size_t     size,
  output logic                       readable,
  output logic                       writable
);
  import sdoes_pkg::*;

  always_comb begin
    known    = 1'b1;
    sub_ok   = (subindex == `SDOES_SUB_0);
    size     = `SDOES_SZ_4;
    readable = 1'b1;
    writable = 1'b1;
    case (index)
      `SDOES_IDX_CTRL:      size = `SDOES_SZ_2;
      `SDOES_IDX_STAT: begin
        size     = `SDOES_SZ_2;
        writable = 1'b0;
      end
      `SDOES_IDX_MODE:      size = `SDOES_SZ_1;
      `SDOES_IDX_POS_ACT:   writable = 1'b0;
      `SDOES_IDX_TGT_POS:   size = `SDOES_SZ_4;
      `SDOES_IDX_HOME_METH: size = `SDOES_SZ_1;
      `SDOES_IDX_HOME_SPD:  sub_ok = (subindex == `SDOES_SUB_1) || (subindex == `SDOES_SUB_2);
      `SDOES_IDX_STORE: begin
        sub_ok   = (subindex == `SDOES_SUB_1);
        readable = 1'b0;
      end
      `SDOES_IDX_MAP: begin
        sub_ok = (subindex == `SDOES_SUB_0) || (subindex == `SDOES_SUB_1);
        size   = (subindex == `SDOES_SUB_0) ? `SDOES_SZ_1 : `SDOES_SZ_4;
      end
      default: begin
        known    = 1'b0;
        sub_ok   = 1'b0;
        readable = 1'b0;
        writable = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ===== hdl/sdoes_homing.sv
// homing tracker: busy from start until origin or abort, sticky origin-found flag
`timescale 1ns/1ps
`default_nettype none
module sdoes_homing (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic start,
  input  wire logic abort,
  input  wire logic origin,
  // state
  output logic      busy,
  output logic      found
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
    end else if (abort || origin) begin
      busy <= 1'b0;
    end
  end

  // a set in the same cycle as a restart wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      found <= 1'b0;
    end else if (busy && origin && !abort) begin
      found <= 1'b1;
    end else if (start) begin
      found <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/sdoes_server.sv
// expedited sdo server: frame decode, object dictionary, replies, ahb-lite registers
// Overview of operation
// - read reply on id 0x580+station, echoes index/subindex, data bytes 4-7.
// - read reply command codes size: 0x4F one byte, 0x4B two, 0x43 four.
// - unserviceable read gets command 0x80 instead of data.
// - each write acknowledged on id 0x580+station echoing index and subindex.
// - write reply command 0x60 on success, 0x80 on failure.
// - every failed access returns an error code naming its cause.
// - unknown or disallowed command byte gives 0x05040001.
// - reading write-only gives 0x06010001; writing read-only gives 0x06010002.
// - missing index gives 0x06020000; bad subindex gives 0x06090011.
// - mapping a non-mappable object gives 0x06040041.
// - in fault state object accesses other than reading the status word fail with 0x06060000.
// - length mismatch 0x06070010, too large 0x06070012, too short 0x06070013.
// - out-of-range write 0x06090030, too large 0x06090031, too small 0x06090032.
// - value blocked by current device state gives 0x08000022.
// - status word bit 15 set once homing finds the origin.
// - expedited command has e=1; s=1 means n counts unused data bytes.
`timescale 1ns/1ps
`default_nettype none
`include "sdoes_regs.svh"
module sdoes_server (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [31:0]      HRDATA,
  // received frame
  input  wire logic        RX_VALID,
  output logic             RX_READY,
  input  wire logic [10:0] RX_ID,
  input  wire logic [3:0]  RX_DLC,
  input  wire logic [63:0] RX_DATA,
  // reply frame
  output logic             TX_VALID,
  input  wire logic        TX_READY,
  output logic [10:0]      TX_ID,
  output logic [3:0]       TX_DLC,
  output logic [63:0]      TX_DATA,
  // drive side
  input  wire logic [6:0]  STATION_SELECT_SWITCH,
  input  wire logic        DRIVE_FAULT,
  input  wire logic        ORIGIN_DETECTED,
  input  wire logic [31:0] POSITION_ACTUAL,
  output logic [15:0]      CONTROL_WORD,
  output logic [7:0]       OPERATION_MODE,
  output logic [31:0]      TARGET_POSITION,
  output logic [7:0]       HOMING_METHOD,
  output logic [31:0]      HOMING_SPEED_SWITCH,
  output logic [31:0]      HOMING_SPEED_ZERO,
  output logic [7:0]       MAP_COUNT,
  output logic [31:0]      MAP_ENTRY,
  output logic             HOMING_BUSY,
  output logic             ORIGIN_FOUND
);
  import sdoes_pkg::*;

  sdoes_state_t state;
  logic [6:0]   station;
  logic [7:0]   ahb_addr, cmd, sub;
  logic [15:0]  idx, status_word;
  logic [31:0]  last_abort, wval, code, rd_val;
  sdoes_size_t  size, wr_len;
  logic         station_valid, sw_fault, ahb_wr, fault, addressed, take;
  logic         is_up, is_dn, known, sub_ok, readable, writable, fail;
  logic         ahb_req, wr_ok, homing_start, homing_abort;

  // keep only the bytes an object of this size holds
  function automatic logic [31:0] f_mask(input logic [31:0] v, input sdoes_size_t s);
    unique case (s)
      `SDOES_SZ_1: return {24'h00_0000, v[7:0]};
      `SDOES_SZ_2: return {16'h0000, v[15:0]};
      default:     return v;
    endcase
  endfunction

  function automatic logic f_mappable(input logic [15:0] i);
    return (i == `SDOES_IDX_CTRL) || (i == `SDOES_IDX_STAT) ||
           (i == `SDOES_IDX_POS_ACT) || (i == `SDOES_IDX_TGT_POS);
  endfunction

  function automatic logic f_mode_ok(input logic [7:0] m);
    return (m == `SDOES_MODE_PP) || (m == `SDOES_MODE_PV) ||
           (m == `SDOES_MODE_PT) || (m == `SDOES_MODE_HOMING);
  endfunction

  sdoes_od_map u_od_map (
    .index    (idx),
    .subindex (sub),
    .known    (known),
    .sub_ok   (sub_ok),
    .size     (size),
    .readable (readable),
    .writable (writable)
  );

  sdoes_homing u_homing (
    .clk    (SYS_CLK),
    .rst_n  (RESET_N),
    .start  (homing_start),
    .abort  (homing_abort),
    .origin (ORIGIN_DETECTED),
    .busy   (HOMING_BUSY),
    .found  (ORIGIN_FOUND)
  );

  // station switch is a strap: caught once after reset release
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      station       <= 7'h00;
      station_valid <= 1'b0;
    end else if (!station_valid) begin
      station       <= STATION_SELECT_SWITCH;
      station_valid <= 1'b1;
    end
  end

  assign fault = DRIVE_FAULT || sw_fault;
  assign cmd   = RX_DATA[7:0];
  assign idx   = RX_DATA[23:8];
  assign sub   = RX_DATA[31:24];
  assign wval  = RX_DATA[63:32];
  // station 0 is illegal, so nothing is served until a real number is strapped
  assign addressed = station_valid && (station != 7'h00) &&
                     (RX_ID == `SDOES_RX_ID_BASE + {4'h0, station}) &&
                     (RX_DLC == `SDOES_FRAME_DLC);
  assign take  = RX_VALID && RX_READY && addressed;
  assign is_up = (cmd == `SDOES_CMD_UPLOAD);
  assign is_dn = (cmd[7:5] == `SDOES_CCS_DOWNLOAD) && !cmd[`SDOES_CMD_RSVD_BIT] &&
                 cmd[`SDOES_CMD_E_BIT];
  // unspecified size takes the object's own size
  assign wr_len = cmd[`SDOES_CMD_S_BIT] ?
                  3'(`SDOES_SZ_4 - {1'b0, cmd[`SDOES_CMD_N_LSB +: 2]}) : size;

  // failure causes in priority order, first match reported
  always_comb begin
    fail = 1'b1;
    code = `SDOES_RST_WORD;
    if (!is_up && !is_dn) begin
      code = `SDOES_AB_CMD;
    end else if (fault && !(is_up && idx == `SDOES_IDX_STAT)) begin
      code = `SDOES_AB_FAULT;
    end else if (!known) begin
      code = `SDOES_AB_NO_INDEX;
    end else if (!sub_ok) begin
      code = `SDOES_AB_SUB;
    end else if (is_up && !readable) begin
      code = `SDOES_AB_WO;
    end else if (is_dn && !writable) begin
      code = `SDOES_AB_RO;
    end else if (is_dn && wr_len == `SDOES_SZ_3) begin
      code = `SDOES_AB_LEN;
    end else if (is_dn && wr_len > size) begin
      code = `SDOES_AB_LEN_HI;
    end else if (is_dn && wr_len < size) begin
      code = `SDOES_AB_LEN_LO;
    end else if (is_dn && idx == `SDOES_IDX_MAP && sub == `SDOES_SUB_1 &&
                 !f_mappable(wval[31:16])) begin
      code = `SDOES_AB_NO_MAP;
    end else if (is_dn && idx == `SDOES_IDX_MAP && sub == `SDOES_SUB_0 &&
                 wval[7:0] > `SDOES_SZ_1) begin
      code = `SDOES_AB_VAL_HI;
    end else if (is_dn && idx == `SDOES_IDX_MODE &&
                 $signed(wval[7:0]) < $signed(`SDOES_MODE_MIN)) begin
      code = `SDOES_AB_VAL_LO;
    end else if (is_dn && idx == `SDOES_IDX_MODE &&
                 $signed(wval[7:0]) > $signed(`SDOES_MODE_MAX)) begin
      code = `SDOES_AB_VAL_HI;
    end else if (is_dn && idx == `SDOES_IDX_MODE && !f_mode_ok(wval[7:0])) begin
      code = `SDOES_AB_RANGE;
    end else if (is_dn && idx == `SDOES_IDX_HOME_METH && wval[7:0] < `SDOES_METH_MIN) begin
      code = `SDOES_AB_VAL_LO;
    end else if (is_dn && idx == `SDOES_IDX_HOME_METH && wval[7:0] > `SDOES_METH_MAX) begin
      code = `SDOES_AB_VAL_HI;
    end else if (is_dn && HOMING_BUSY &&
                 (idx == `SDOES_IDX_MODE || idx == `SDOES_IDX_HOME_METH)) begin
      // changing mode or method mid-homing would corrupt the search
      code = `SDOES_AB_STATE;
    end else begin
      fail = 1'b0;
    end
  end

  always_comb begin
    status_word = 16'h0000;
    status_word[`SDOES_SW_ORIGIN] = ORIGIN_FOUND;
    status_word[`SDOES_SW_HOMING] = HOMING_BUSY;
    status_word[`SDOES_SW_FAULT]  = fault;
    status_word[2:0] = {3{(CONTROL_WORD[3:0] == `SDOES_CTRL_ENABLE) && !fault}};
  end

  always_comb begin
    rd_val = `SDOES_RST_WORD;
    case (idx)
      `SDOES_IDX_CTRL:      rd_val = {16'h0000, CONTROL_WORD};
      `SDOES_IDX_STAT:      rd_val = {16'h0000, status_word};
      `SDOES_IDX_MODE:      rd_val = {24'h00_0000, OPERATION_MODE};
      `SDOES_IDX_POS_ACT:   rd_val = POSITION_ACTUAL;
      `SDOES_IDX_TGT_POS:   rd_val = TARGET_POSITION;
      `SDOES_IDX_HOME_METH: rd_val = {24'h00_0000, HOMING_METHOD};
      `SDOES_IDX_HOME_SPD:  rd_val = (sub == `SDOES_SUB_1) ? HOMING_SPEED_SWITCH
                                                          : HOMING_SPEED_ZERO;
      `SDOES_IDX_MAP:       rd_val = (sub == `SDOES_SUB_0) ? {24'h00_0000, MAP_COUNT}
                                                          : MAP_ENTRY;
    endcase
  end

  assign wr_ok = take && is_dn && !fail;
  // homing starts on a rising start bit with the drive enabled in homing mode
  assign homing_start = wr_ok && idx == `SDOES_IDX_CTRL && wval[`SDOES_CTRL_START] &&
                        !CONTROL_WORD[`SDOES_CTRL_START] &&
                        wval[3:0] == `SDOES_CTRL_ENABLE &&
                        OPERATION_MODE == `SDOES_MODE_HOMING;
  assign homing_abort = fault || (wr_ok && idx == `SDOES_IDX_CTRL &&
                                  !wval[`SDOES_CTRL_START]);

  // object stores
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      CONTROL_WORD        <= `SDOES_RST_CTRL;
      OPERATION_MODE      <= `SDOES_RST_MODE;
      TARGET_POSITION     <= `SDOES_RST_WORD;
      HOMING_METHOD       <= `SDOES_RST_MODE;
      HOMING_SPEED_SWITCH <= `SDOES_RST_WORD;
      HOMING_SPEED_ZERO   <= `SDOES_RST_WORD;
      MAP_COUNT           <= `SDOES_RST_MODE;
      MAP_ENTRY           <= `SDOES_RST_WORD;
    end else if (wr_ok) begin
      case (idx)
        `SDOES_IDX_CTRL:      CONTROL_WORD    <= wval[15:0];
        `SDOES_IDX_MODE:      OPERATION_MODE  <= wval[7:0];
        `SDOES_IDX_TGT_POS:   TARGET_POSITION <= wval;
        `SDOES_IDX_HOME_METH: HOMING_METHOD   <= wval[7:0];
        `SDOES_IDX_HOME_SPD: begin
          if (sub == `SDOES_SUB_1) begin
            HOMING_SPEED_SWITCH <= wval;
          end else begin
            HOMING_SPEED_ZERO <= wval;
          end
        end
        `SDOES_IDX_MAP: begin
          if (sub == `SDOES_SUB_0) begin
            MAP_COUNT <= wval[7:0];
          end else begin
            MAP_ENTRY <= wval;
          end
        end
        default: ;
      endcase
    end
  end

  // one request in flight: intake closes until the reply is taken
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state    <= SDOES_IDLE;
      RX_READY <= 1'b1;
      TX_VALID <= 1'b0;
    end else begin
      unique case (state)
        SDOES_IDLE: begin
          if (take) begin
            state    <= SDOES_REPLY;
            RX_READY <= 1'b0;
            TX_VALID <= 1'b1;
          end
        end
        SDOES_REPLY: begin
          if (TX_READY) begin
            state    <= SDOES_IDLE;
            RX_READY <= 1'b1;
            TX_VALID <= 1'b0;
          end
        end
      endcase
    end
  end

  // reply frame, held until taken
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TX_ID   <= 11'h000;
      TX_DLC  <= 4'h0;
      TX_DATA <= {2{`SDOES_RST_WORD}};
    end else if (take) begin
      TX_ID  <= `SDOES_TX_ID_BASE + {4'h0, station};
      TX_DLC <= `SDOES_FRAME_DLC;
      TX_DATA[31:8] <= {sub, idx};
      if (fail) begin
        TX_DATA[7:0]   <= `SDOES_CMD_ABORT;
        TX_DATA[63:32] <= code;
      end else if (is_up) begin
        TX_DATA[63:32] <= f_mask(rd_val, size);
        unique case (size)
          `SDOES_SZ_1: TX_DATA[7:0] <= `SDOES_CMD_RD_1;
          `SDOES_SZ_2: TX_DATA[7:0] <= `SDOES_CMD_RD_2;
          default:     TX_DATA[7:0] <= `SDOES_CMD_RD_4;
        endcase
      end else begin
        TX_DATA[7:0]   <= `SDOES_CMD_WR_ACK;
        TX_DATA[63:32] <= f_mask(wval, size);
      end
    end
  end

  // ahb-lite: zero wait states, read data fetched in the address phase
  assign ahb_req = HSEL && HTRANS[1] && HREADY;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ahb_wr    <= 1'b0;
      ahb_addr  <= 8'h00;
      HRDATA    <= `SDOES_RST_WORD;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      ahb_wr    <= ahb_req && HWRITE;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (ahb_req) begin
        ahb_addr <= HADDR[7:0];
      end
      if (ahb_req && !HWRITE) begin
        case (HADDR[7:0])
          `SDOES_REG_CTRL:   HRDATA <= {31'h0000_0000, sw_fault};
          `SDOES_REG_STATUS: HRDATA <= {16'h0000, status_word};
          `SDOES_REG_ABORT:  HRDATA <= last_abort;
          default:           HRDATA <= `SDOES_RST_WORD;
        endcase
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sw_fault <= 1'b0;
    end else if (ahb_wr && ahb_addr == `SDOES_REG_CTRL) begin
      sw_fault <= HWDATA[0];
    end
  end

  // a new abort beats a software clear in the same cycle
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      last_abort <= `SDOES_RST_WORD;
    end else if (take && fail) begin
      last_abort <= code;
    end else if (ahb_wr && ahb_addr == `SDOES_REG_ABORT) begin
      last_abort <= `SDOES_RST_WORD;
    end
  end
endmodule
`default_nettype wire

// ===== verification/sdoes_server_props.sv
// assertions on the ports of the expedited sdo server
`timescale 1ns/1ps
`default_nettype none
module sdoes_server_props (
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  // bus and frames
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        RX_VALID,
  input wire logic        RX_READY,
  input wire logic [10:0] RX_ID,
  input wire logic [3:0]  RX_DLC,
  input wire logic [63:0] RX_DATA,
  input wire logic        TX_VALID,
  input wire logic        TX_READY,
  input wire logic [10:0] TX_ID,
  input wire logic [3:0]  TX_DLC,
  input wire logic [63:0] TX_DATA,
  // drive side
  input wire logic [6:0]  STATION_SELECT_SWITCH,
  input wire logic        HOMING_BUSY,
  input wire logic        ORIGIN_FOUND
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  wire logic [10:0] stn = {4'h0, STATION_SELECT_SWITCH};
  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
  take_reply_a: assert property (RX_VALID && RX_READY && $past(RESET_N) && stn != 11'h0
    && RX_ID == 11'h600 + stn && RX_DLC == 4'h8 |=> TX_VALID)
    else $error("no reply");
  reply_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("reply not held");
  reply_done_a: assert property (TX_VALID && TX_READY |=> !TX_VALID && RX_READY)
    else $error("reply not retired");
  one_open_a: assert property (TX_VALID |-> !RX_READY)
    else $error("two requests open");
  reply_addr_a: assert property (TX_VALID |-> TX_ID == 11'h580 + stn && TX_DLC == 4'h8)
    else $error("bad reply header");
  echo_addr_a: assert property ($rose(TX_VALID) |-> TX_DATA[31:8] == $past(RX_DATA[31:8]))
    else $error("address not echoed");
  reply_cmd_a: assert property (TX_VALID |-> TX_DATA[7:0] inside {8'h4F, 8'h4B,
    8'h43, 8'h60, 8'h80})
    else $error("reply command not legal");
  abort_code_a: assert property (TX_VALID && TX_DATA[7:0] == 8'h80 |-> TX_DATA[63:32] != 0)
    else $error("abort without code");
  origin_cause_a: assert property ($rose(ORIGIN_FOUND) |-> $past(HOMING_BUSY))
    else $error("origin found outside homing");
endmodule
`default_nettype wire

// ===== verification/sdoes_master.sv
// can master model: offers one request, then takes the reply
`timescale 1ns/1ps
`default_nettype none
module sdoes_master (
  // clock
  input  wire logic        clk,
  // request
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [10:0]      rx_id,
  output logic [3:0]       rx_dlc,
  output logic [63:0]      rx_data,
  // reply
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [63:0] tx_data
);
  initial {rx_valid, tx_ready, rx_id, rx_dlc, rx_data} = '0;
  task automatic xfer(input logic [10:0] id, input logic [63:0] f, input int st,
                      output logic [63:0] rep, output logic ok);
    int n;
    n = 0;
    rx_id <= id;
    rx_dlc <= 4'h8;
    rx_data <= f;
    rx_valid <= 1'b1;
    do begin @(posedge clk); n++; end while (rx_ready !== 1'b1 && n < 60);
    rx_valid <= 1'b0;
    // released lines flip so stale bytes cannot pass for a fresh frame
    rx_data <= ~f;
    do begin @(posedge clk); n++; end while (tx_valid !== 1'b1 && n < 60);
    repeat (st) @(posedge clk);
    tx_ready <= 1'b1;
    do begin @(posedge clk); n++; end while (tx_valid !== 1'b1 && n < 60);
    rep = tx_data;
    tx_ready <= 1'b0;
    ok = n < 60;
  endtask
endmodule
`default_nettype wire

// ===== verification/sdoes_server_tb.sv
// testbench of the expedited sdo server
`timescale 1ns/1ps
`default_nettype none
module sdoes_server_tb;
  import sdoes_pkg::*;
  localparam logic [6:0] STN = 7'h05;
  logic        sys_clk, reset_n, hsel, hwrite, fault, origin, rx_valid, rx_ready, ok;
  logic        hreadyout, hresp, tx_valid, tx_ready, homing_busy, origin_found;
  logic [1:0]  htrans;
  logic [3:0]  rx_dlc, tx_dlc;
  logic [7:0]  om, hm;
  logic [15:0] cw;
  logic [10:0] rx_id, tx_id;
  logic [31:0] haddr, hwdata, hrdata, pos, r;
  logic [31:0] lf = 32'h0001_1E7F;
  logic [63:0] rx_data, tx_data, rep;
  int          err_count, total_checks;
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  sdoes_server DUT (.SYS_CLK(sys_clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .RX_ID(rx_id), .RX_DLC(rx_dlc), .RX_DATA(rx_data),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_ID(tx_id), .TX_DLC(tx_dlc),
    .TX_DATA(tx_data), .STATION_SELECT_SWITCH(STN), .DRIVE_FAULT(fault),
    .ORIGIN_DETECTED(origin), .POSITION_ACTUAL(pos), .CONTROL_WORD(cw), .OPERATION_MODE(om),
    .TARGET_POSITION(), .HOMING_METHOD(hm), .HOMING_SPEED_SWITCH(), .HOMING_SPEED_ZERO(),
    .MAP_COUNT(), .MAP_ENTRY(), .HOMING_BUSY(homing_busy), .ORIGIN_FOUND(origin_found));
  sdoes_master M (.clk(sys_clk), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_id(rx_id),
    .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [63:0] reply(input logic [7:0] c, input logic [15:0] i,
                                        input logic [7:0] s, input logic [31:0] d);
    return {d, s, i, c};
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic fail(input string m);
    $display("[FAIL] %0t %s", $time, m);
    err_count++;
  endtask
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) fail($sformatf("got %h expected %h", g, e));
  endtask
  task automatic chk1(input logic g, input logic e);
    total_checks++;
    if (g !== e) fail("flag wrong");
  endtask
  task automatic xf(input logic [63:0] f);
    M.xfer(11'h600 + STN, f, int'(lf[1:0]), rep, ok);
    lf = nx(lf);
    if (!ok) begin fail("reply timeout"); print_verdict(); end
  endtask
  task automatic sdo(input logic [7:0] c, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] v, input logic [7:0] ec, input logic [31:0] ed);
    xf({v, s, i, c});
    chk(rep, reply(ec, i, s, ed));
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge sys_clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    r = hrdata;
    if (n >= 50) begin fail("bus timeout"); print_verdict(); end
  endtask
  initial begin
    {hsel, hwrite, fault, origin, htrans, haddr, hwdata, pos} = '0;
    err_count = 0;
    total_checks = 0;
    reset_n = 1'b0;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    pos <= lf;
    repeat (3) @(posedge sys_clk);
    sdo(8'h2B, 16'h6040, 8'h00, 32'h0000_000F, 8'h60, 32'h0000_000F);
    sdo(8'h2F, 16'h6060, 8'h00, 32'h0000_0006, 8'h60, 32'h0000_0006);
    sdo(8'h2F, 16'h6098, 8'h00, 32'h0000_0021, 8'h60, 32'h0000_0021);
    sdo(8'h23, 16'h6099, 8'h01, lf, 8'h60, lf);
    sdo(8'h40, 16'h6060, 8'h00, 32'h0, 8'h4F, 32'h0000_0006);
    sdo(8'h40, 16'h6040, 8'h00, 32'h0, 8'h4B, 32'h0000_000F);
    sdo(8'h40, 16'h6064, 8'h00, 32'h0, 8'h43, pos);
    $display("test access done");
    sdo(8'h41, 16'h6040, 8'h00, 32'h0, 8'h80, 32'h0504_0001);
    sdo(8'h40, 16'h1010, 8'h01, 32'h0, 8'h80, 32'h0601_0001);
    sdo(8'h2B, 16'h6041, 8'h00, 32'h1, 8'h80, 32'h0601_0002);
    sdo(8'h40, 16'h1234, 8'h00, 32'h0, 8'h80, 32'h0602_0000);
    sdo(8'h40, 16'h6040, 8'h05, 32'h0, 8'h80, 32'h0609_0011);
    sdo(8'h23, 16'h1A00, 8'h01, 32'h6060_0008, 8'h80, 32'h0604_0041);
    sdo(8'h27, 16'h6040, 8'h00, 32'h1, 8'h80, 32'h0607_0010);
    sdo(8'h23, 16'h6040, 8'h00, 32'h1, 8'h80, 32'h0607_0012);
    sdo(8'h2B, 16'h607A, 8'h00, 32'h1, 8'h80, 32'h0607_0013);
    sdo(8'h2F, 16'h6060, 8'h00, 32'h2, 8'h80, 32'h0609_0030);
    sdo(8'h2F, 16'h6060, 8'h00, 32'hB, 8'h80, 32'h0609_0031);
    sdo(8'h2F, 16'h6060, 8'h00, 32'h0, 8'h80, 32'h0609_0032);
    $display("test abort done");
    sdo(8'h2B, 16'h6040, 8'h00, 32'h1F, 8'h60, 32'h1F);
    chk1(homing_busy, 1'b1);
    chk({cw, om, hm}, {16'h001F, 8'h06, 8'h21});
    sdo(8'h2F, 16'h6060, 8'h00, 32'h6, 8'h80, 32'h0800_0022);
    origin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    xf(64'h0000_0000_0060_4140);
    chk1(rep[47], 1'b1);
    chk1(origin_found, 1'b1);
    $display("test homing done");
    ahb(1'b1, 8'h00, 32'h1);
    sdo(8'h40, 16'h6040, 8'h00, 32'h0, 8'h80, 32'h0606_0000);
    ahb(1'b1, 8'h00, 32'h0);
    fault <= 1'b1;
    sdo(8'h2F, 16'h6060, 8'h00, 32'h1, 8'h80, 32'h0606_0000);
    fault <= 1'b0;
    ahb(1'b0, 8'h08, 32'h0);
    chk(r, 32'h0606_0000);
    ahb(1'b1, 8'h08, 32'h0);
    ahb(1'b0, 8'h08, 32'h0);
    chk(r, 32'h0);
    ahb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h0C, 32'h0);
    chk(r, 32'h0);
    ahb(1'b0, 8'h04, 32'h0);
    chk1(r[15], 1'b1);
    $display("test registers done");
    print_verdict();
  end
endmodule
bind sdoes_server sdoes_server_props P (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
  .RX_ID(RX_ID), .RX_DLC(RX_DLC), .RX_DATA(RX_DATA), .TX_VALID(TX_VALID),
  .TX_READY(TX_READY), .TX_ID(TX_ID), .TX_DLC(TX_DLC), .TX_DATA(TX_DATA),
  .STATION_SELECT_SWITCH(STATION_SELECT_SWITCH), .HOMING_BUSY(HOMING_BUSY),
  .ORIGIN_FOUND(ORIGIN_FOUND));
`default_nettype wire
